/* File: inc/scmc_consts.vh */
// constants for the secondary clock mode control block
`ifndef SCMC_CONSTS_VH
`define SCMC_CONSTS_VH

`define SCMC_NUM_CLKS        10
`define SCMC_MASK_CNT_W      4
`define SCMC_MASK_LEN        4'ha

`define SCMC_ADDR_W          12
`define SCMC_OFF_CTRL        12'h000
`define SCMC_OFF_STATUS      12'h004
`define SCMC_OFF_MASK        12'h008

`define SCMC_PWR_LO          0
`define SCMC_PWR_HI          1
`define SCMC_PWR_D3HOT       2'h3
`define SCMC_PWR_D0          2'h0
`define SCMC_DIS_LO          16
`define SCMC_DIS_HI          25
`define SCMC_DIS_RESET       10'h000

`define SCMC_ST_SYNC         0
`define SCMC_ST_ASYNC        1
`define SCMC_ST_INVALID      2
`define SCMC_ST_SPEED66      3
`define SCMC_ST_SCAN_CAP     4
`define SCMC_ST_SCAN_SHIFT   5
`define SCMC_ST_MASK_DONE    6
`define SCMC_ST_B2           7
`define SCMC_ST_RECV_LO      8
`define SCMC_ST_RECV_HI      9

`define SCMC_MODE_SYNC       2'h2
`define SCMC_MODE_ASYNC      2'h3

`define SCMC_RX_IDLE         2'h0
`define SCMC_RX_SHIFT        2'h1
`define SCMC_RX_DONE         2'h2

`endif

/* File: logic/scmc_top.v */
// secondary clock mode control: straps, serial clock mask, secondary clock generation, apb registers
// Behaviour
// R1 - shared pin is serial mask input in sync mode, async clock input in async mode
// R2 - mask reception starts once primary reset released while secondary reset still asserted
// R3 - mask bits shift into clock control register, which disables matching clock outputs
// R4 - mask input held low leaves every secondary clock enabled
// R5 - mask input held high drives every secondary clock constantly high
// R6 - async mode derives all ten secondary clocks from the async clock input
// R7 - management pin high plus D3hot stops secondary clocks at zero (B2)
// R8 - management pin low leaves clocks unchanged on entering D3hot
// R9 - sync mode runs 66 MHz with speed strap high, 33 MHz when low; here only speed_66 follows the strap, sync clocks always run at pclk/2
// R10 - async divider select 0 halves input frequency, 1 passes it through
// R11 - test mode: scan enable high gives capture, low gives shift
// R12 - two mode-select inputs choose synchronous or asynchronous operation
// R13 - mode 1,0 is synchronous, 1,1 asynchronous; first bit 0 is reserved
// R14 - board holds all straps static; device treats them as configuration
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "scmc_consts.vh"

module scmc_top (
  input  wire                        pclk,                    // 100 MHz clock
  input  wire                        presetn,                 // async reset, active low
  input  wire                        psel,                    // apb select
  input  wire                        penable,                 // apb enable
  input  wire                        pwrite,                  // apb write
  input  wire [`SCMC_ADDR_W-1:0]     paddr,                   // apb byte address
  input  wire [31:0]                 pwdata,                  // apb write data
  output reg  [31:0]                 prdata,                  // apb read data
  output reg                         pready,                  // apb ready
  output reg                         pslverr,                 // apb error on unmapped address
  input  wire                        mode_select_first,       // mode strap bit 1
  input  wire                        mode_select_second,      // mode strap bit 0
  input  wire                        speed_config_strap,      // 66 MHz / scan enable / divider select
  input  wire                        test_mode,               // scan test mode
  input  wire                        clock_mask_serial_in,    // serial mask or async clock
  input  wire                        primary_reset_n,         // primary bus reset, active low
  input  wire                        secondary_reset_out_n,   // secondary bus reset, active low
  input  wire                        bus_power_clock_mgmt_pin,// clock stop enable in D3hot
  output reg  [`SCMC_NUM_CLKS-1:0]   secondary_clock_outputs, // secondary clocks
  output reg                         sync_mode,               // synchronous mode active
  output reg                         async_mode,              // asynchronous mode active
  output reg                         speed_66,                // 66 MHz operation selected
  output reg                         scan_capture,            // full scan parallel operation
  output reg                         scan_shift               // full scan shift operation
);

  wire [1:0] mode_sel = {mode_select_first, mode_select_second};
  // straps are static configuration, so no resampling is needed
  wire       is_sync  = (mode_sel == `SCMC_MODE_SYNC);        // [R12] [R13] [R14]
  wire       is_async = (mode_sel == `SCMC_MODE_ASYNC);       // [R12] [R13]
  wire       invalid  = ~mode_select_first;                   // [R13]

  ////////////////////////////////////////////////////////////////////////////
  // serial clock mask reception

  reg [1:0]                    rx_state;
  reg [1:0]                    next_rx_state;
  reg [`SCMC_MASK_CNT_W-1:0]   rx_count;
  reg [`SCMC_NUM_CLKS-1:0]     clock_mask;

  wire rx_window = primary_reset_n & ~secondary_reset_out_n;  // [R2]

  always @* begin
    next_rx_state = rx_state;
    case (rx_state)
      `SCMC_RX_IDLE: begin
        if (is_sync && rx_window) begin
          next_rx_state = `SCMC_RX_SHIFT;                     // [R2]
        end
      end
      `SCMC_RX_SHIFT: begin
        if (!is_sync) begin
          next_rx_state = `SCMC_RX_IDLE;
        end else if (rx_count == `SCMC_MASK_LEN - 4'h1) begin
          next_rx_state = `SCMC_RX_DONE;
        end
      end
      `SCMC_RX_DONE: begin
        // a new primary reset rearms reception
        if (!primary_reset_n) begin
          next_rx_state = `SCMC_RX_IDLE;
        end
      end
      default: begin
        next_rx_state = `SCMC_RX_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state   <= `SCMC_RX_IDLE;
      rx_count   <= {`SCMC_MASK_CNT_W{1'b0}};
      clock_mask <= {`SCMC_NUM_CLKS{1'b0}};
    end else begin
      rx_state <= next_rx_state;
      if (rx_state == `SCMC_RX_SHIFT && is_sync) begin
        // shared pin read as mask data only in sync mode
        clock_mask <= {clock_mask[`SCMC_NUM_CLKS-2:0], clock_mask_serial_in}; // [R1] [R3]
        rx_count   <= rx_count + 4'h1;
      end else if (rx_state == `SCMC_RX_IDLE) begin
        rx_count <= {`SCMC_MASK_CNT_W{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb registers

  reg [1:0]                  power_state;
  reg [`SCMC_NUM_CLKS-1:0]   sw_disable;
  reg [31:0]                 next_rdata;
  reg                        addr_ok;

  wire d3hot   = (power_state == `SCMC_PWR_D3HOT);
  wire b2_stop = d3hot & bus_power_clock_mgmt_pin;           // [R7] [R8]
  wire apb_acc = psel & penable & pready;
  wire apb_wr  = apb_acc & pwrite & (paddr == `SCMC_OFF_CTRL);

  always @* begin
    next_rdata = 32'h0000_0000;
    addr_ok    = 1'b1;
    case (paddr)
      `SCMC_OFF_CTRL: begin
        next_rdata[`SCMC_PWR_HI:`SCMC_PWR_LO] = power_state;
        next_rdata[`SCMC_DIS_HI:`SCMC_DIS_LO] = sw_disable;
      end
      `SCMC_OFF_STATUS: begin
        next_rdata[`SCMC_ST_SYNC]       = sync_mode;
        next_rdata[`SCMC_ST_ASYNC]      = async_mode;
        next_rdata[`SCMC_ST_INVALID]    = invalid;
        next_rdata[`SCMC_ST_SPEED66]    = speed_66;
        next_rdata[`SCMC_ST_SCAN_CAP]   = scan_capture;
        next_rdata[`SCMC_ST_SCAN_SHIFT] = scan_shift;
        next_rdata[`SCMC_ST_MASK_DONE]  = (rx_state == `SCMC_RX_DONE);
        next_rdata[`SCMC_ST_B2]         = b2_stop;
        next_rdata[`SCMC_ST_RECV_HI:`SCMC_ST_RECV_LO] = rx_state;
      end
      `SCMC_OFF_MASK: begin
        next_rdata[`SCMC_NUM_CLKS-1:0] = clock_mask;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // one wait state keeps prdata and pready straight from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
      power_state <= `SCMC_PWR_D0;
      sw_disable  <= `SCMC_DIS_RESET;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
      if (apb_wr) begin
        power_state <= pwdata[`SCMC_PWR_HI:`SCMC_PWR_LO];
        sw_disable  <= pwdata[`SCMC_DIS_HI:`SCMC_DIS_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // secondary clock generation

  reg sync_clk;
  reg async_prev;
  reg async_half;

  wire async_rise = clock_mask_serial_in & ~async_prev;
  // divider select 0 halves, 1 follows the sampled input; sampling limits input to below pclk/2
  wire async_clk  = speed_config_strap ? clock_mask_serial_in : async_half; // [R10]

  // mask bit set parks the clock high; software disable also parks high
  wire [`SCMC_NUM_CLKS-1:0] sync_park  = clock_mask | sw_disable;   // [R3] [R4] [R5]
  wire [`SCMC_NUM_CLKS-1:0] async_park = sw_disable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_clk                <= 1'b0;
      async_prev              <= 1'b0;
      async_half              <= 1'b0;
      secondary_clock_outputs <= {`SCMC_NUM_CLKS{1'b0}};
      sync_mode               <= 1'b0;
      async_mode              <= 1'b0;
      speed_66                <= 1'b0;
      scan_capture            <= 1'b0;
      scan_shift              <= 1'b0;
    end else begin
      sync_clk   <= ~sync_clk;
      async_prev <= clock_mask_serial_in;                     // [R1]
      if (async_rise) begin
        async_half <= ~async_half;
      end
      sync_mode    <= is_sync;                                // [R12]
      async_mode   <= is_async;                               // [R12]
      speed_66     <= is_sync & ~test_mode & speed_config_strap; // [R9]
      scan_capture <= is_sync & test_mode & speed_config_strap;  // [R11]
      scan_shift   <= is_sync & test_mode & ~speed_config_strap; // [R11]
      if (b2_stop || invalid) begin
        secondary_clock_outputs <= {`SCMC_NUM_CLKS{1'b0}};    // [R7] [R13]
      end else if (is_async) begin
        secondary_clock_outputs <= {`SCMC_NUM_CLKS{async_clk}} | async_park; // [R6] [R10]
      end else begin
        secondary_clock_outputs <= {`SCMC_NUM_CLKS{sync_clk}} | sync_park;   // [R3] [R8]
      end
    end
  end

endmodule // scmc_top

/* File: tb/scmc_properties.sv */
// port assertions for the secondary clock mode control block
`timescale 1ns/1ps
`include "scmc_consts.vh"
module scmc_properties (
  input wire                      pclk,                     // clock
  input wire                      presetn,                  // reset
  input wire                      psel,                     // apb
  input wire                      penable,                  // apb
  input wire                      pwrite,                   // apb
  input wire                      pready,                   // apb
  input wire [`SCMC_ADDR_W-1:0]   paddr,                    // apb
  input wire [31:0]               pwdata,                   // apb
  input wire                      mode_select_first,        // strap
  input wire                      mode_select_second,       // strap
  input wire                      speed_config_strap,       // strap
  input wire                      test_mode,                // strap
  input wire                      bus_power_clock_mgmt_pin, // strap
  input wire [`SCMC_NUM_CLKS-1:0] secondary_clock_outputs,  // clocks
  input wire                      sync_mode,                // level
  input wire                      async_mode,               // level
  input wire                      speed_66,                 // level
  input wire                      scan_capture,             // level
  input wire                      scan_shift                // level
);
  wire wr_d3 = psel & penable & pready & pwrite & (paddr == `SCMC_OFF_CTRL) & (pwdata[1:0] == `SCMC_PWR_D3HOT);
  // presetn in the antecedent: flops are still held in reset at the releasing edge
  wire s_mode = presetn & mode_select_first & ~mode_select_second;
  wire a_mode = presetn & mode_select_first & mode_select_second;
  wire sync_n = s_mode & ~test_mode;
  wire sync_t = s_mode & test_mode;
  wire clk_even = (secondary_clock_outputs == 10'h000) || (secondary_clock_outputs == 10'h3ff);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  mode_sync_a: assert property (s_mode |=> sync_mode && !async_mode)
    else $error("sync strap not decoded");
  mode_async_a: assert property (a_mode |=> async_mode && !sync_mode)
    else $error("async strap not decoded");
  speed_sel_a: assert property (sync_n |=> speed_66 == $past(speed_config_strap))
    else $error("speed select wrong");
  scan_sel_a: assert property (sync_t |=> scan_capture == $past(speed_config_strap) && scan_shift != scan_capture)
    else $error("scan operation wrong");
  async_same_a: assert property (async_mode && $past(async_mode, 2) |-> clk_even)
    else $error("async clocks differ");
  b2_stop_a: assert property (wr_d3 && bus_power_clock_mgmt_pin |-> ##3 (secondary_clock_outputs == 10'h000) [*4])
    else $error("clocks not stopped in D3hot");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
endmodule  // scmc_properties

bind scmc_top scmc_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .paddr(paddr), .pwdata(pwdata), .mode_select_first(mode_select_first), .mode_select_second(mode_select_second),
  .speed_config_strap(speed_config_strap), .test_mode(test_mode),
  .bus_power_clock_mgmt_pin(bus_power_clock_mgmt_pin), .secondary_clock_outputs(secondary_clock_outputs),
  .sync_mode(sync_mode), .async_mode(async_mode), .speed_66(speed_66), .scan_capture(scan_capture),
  .scan_shift(scan_shift)
);

/* File: tb/scmc_board.sv */
// board model: mode straps, clock mask stream and async secondary clock
`timescale 1ns/1ps
module scmc_board (
  input  wire pclk,                     // bench clock
  output reg  mode_select_first,        // mode strap
  output reg  mode_select_second,       // mode strap
  output reg  speed_config_strap,       // speed, scan or divider strap
  output reg  test_mode,                // scan test strap
  output reg  bus_power_clock_mgmt_pin, // clock stop enable
  output wire clock_mask_serial_in,     // shared mask or clock pin
  output reg  primary_reset_n,          // primary reset
  output reg  secondary_reset_out_n     // secondary reset
);
  reg aclk_on = 1'b0;
  reg aclk    = 1'b0;
  reg msk     = 1'b0;
  // oscillator phase never meets a rising pclk edge
  always #36 aclk = ~aclk;
  assign clock_mask_serial_in = aclk_on ? aclk : msk;
  initial begin
    mode_select_first = 1'b1;
    {mode_select_second, speed_config_strap, test_mode, bus_power_clock_mgmt_pin} = 4'h0;
    primary_reset_n = 1'b0;
    secondary_reset_out_n = 1'b0;
  end
  // straps only move while the device is held in reset
  task strap(input [4:0] v);
    {mode_select_second, speed_config_strap, test_mode, bus_power_clock_mgmt_pin, aclk_on} <= v;
  endtask
  task send(input [9:0] m);
    integer i;
    begin
      primary_reset_n <= 1'b0;
      secondary_reset_out_n <= 1'b0;
      @(posedge pclk);
      primary_reset_n <= 1'b1;
      @(posedge pclk);
      for (i = 9; i >= 0; i = i - 1) begin
        msk <= m[i];
        @(posedge pclk);
      end
      msk <= ~m[0];
      secondary_reset_out_n <= 1'b1;
    end
  endtask
endmodule  // scmc_board

/* File: tb/scmc_top_tb.sv */
// self-checking bench for the secondary clock mode control block
`timescale 1ns/1ps
`include "scmc_consts.vh"
module scmc_top_tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel, penable, pwrite, ps;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd, v;
  reg  [9:0]  m, o1, o2;
  wire [31:0] prdata;
  wire        pready, pslverr, mode_select_first, mode_select_second, speed_config_strap, test_mode;
  wire        bus_power_clock_mgmt_pin, clock_mask_serial_in, primary_reset_n, secondary_reset_out_n;
  wire [9:0]  secondary_clock_outputs;
  wire        sync_mode, async_mode, speed_66, scan_capture, scan_shift;
  integer     n_fail = 0, total_checks = 0, t, k, na, ni, pp, pa;
  always #5 pclk = ~pclk;
  scmc_board u_board (
    .pclk(pclk), .mode_select_first(mode_select_first), .mode_select_second(mode_select_second),
    .speed_config_strap(speed_config_strap), .test_mode(test_mode),
    .bus_power_clock_mgmt_pin(bus_power_clock_mgmt_pin), .clock_mask_serial_in(clock_mask_serial_in),
    .primary_reset_n(primary_reset_n), .secondary_reset_out_n(secondary_reset_out_n)
  );
  scmc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_select_first(mode_select_first), .mode_select_second(mode_select_second),
    .speed_config_strap(speed_config_strap), .test_mode(test_mode),
    .clock_mask_serial_in(clock_mask_serial_in), .primary_reset_n(primary_reset_n),
    .secondary_reset_out_n(secondary_reset_out_n), .bus_power_clock_mgmt_pin(bus_power_clock_mgmt_pin),
    .secondary_clock_outputs(secondary_clock_outputs), .sync_mode(sync_mode), .async_mode(async_mode),
    .speed_66(speed_66), .scan_capture(scan_capture), .scan_shift(scan_shift)
  );
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k = k + 1; end while (pready !== 1'b1 && k < 20);
      rd = prdata; ps = pslverr;
      if (pready !== 1'b1) begin n_fail = n_fail + 1; close_out; end
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rst(input [4:0] s);
    begin
      presetn <= 1'b0;
      u_board.strap(s);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
    end
  endtask
  task watch;
    begin
      repeat (3) @(posedge pclk);
      o1 = secondary_clock_outputs;
      @(posedge pclk);
      o2 = secondary_clock_outputs;
    end
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 0;
    v = $urandom(98);
    v = $urandom;
    rst({1'b0, v[0], 3'b000});
    check(speed_66, v[0]);
    apb(1'b0, `SCMC_OFF_STATUS, 0);
    check(rd[3:0], {v[0], 3'b001});
    check(ps, 0);
    apb(1'b0, 12'h00c, 0);
    check(ps, 1);
    check(rd, 0);
    $display("strap test done");
    for (t = 0; t < 3; t = t + 1) begin
      m = (t == 0) ? 10'h000 : (t == 1) ? 10'h3ff : $urandom;
      u_board.send(m);
      apb(1'b0, `SCMC_OFF_MASK, 0);
      check(rd, m);
      watch;
      check(o1 & o2 & m, m);
      check((o1 ^ o2) | m, 10'h3ff);
      $display("mask test %0d done", t);
    end
    apb(1'b1, `SCMC_OFF_CTRL, 3);
    watch;
    check((o1 ^ o2) | m, 10'h3ff);
    rst(5'b00010);
    apb(1'b1, `SCMC_OFF_CTRL, 3);
    watch;
    check(o1 | o2, 0);
    $display("power tests done");
    for (t = 0; t < 2; t = t + 1) begin
      rst({1'b0, t[0], 3'b100});
      check({scan_capture, scan_shift}, {t[0], !t[0]});
      rst({1'b1, t[0], 3'b001});
      {na, ni, pp, pa} = 0;
      repeat (700) begin
        @(posedge pclk);
        ni = ni + (clock_mask_serial_in & !pp);
        na = na + (secondary_clock_outputs[0] & !pa);
        pp = clock_mask_serial_in;
        pa = secondary_clock_outputs[0];
      end
      k = t ? ni : ni / 2;
      check(async_mode, 1);
      check(na >= k - 1 && na <= k + 1, 1);
      $display("mode test %0d done", t);
    end
    close_out;
  end
endmodule  // scmc_top_tb
